// ### common/fis_pkg.sv
package fis_pkg;
    // opcodes
    localparam logic [7:0] OP_RD_SR1    = 8'h05;
    localparam logic [7:0] OP_RD_SR2    = 8'h35;
    localparam logic [7:0] OP_RD_SR3    = 8'h15;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_EN_VOL = 8'h50;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_WR_SR1    = 8'h01;
    localparam logic [7:0] OP_WR_SR2    = 8'h31;
    localparam logic [7:0] OP_WR_SR3    = 8'h11;
    localparam logic [7:0] OP_SUSPEND   = 8'h75;
    localparam logic [7:0] OP_PWR_DOWN  = 8'hb9;
    localparam logic [7:0] OP_RELEASE   = 8'hab;
    localparam logic [7:0] OP_ID_LEGACY = 8'h90;
    localparam logic [7:0] OP_ID_DUAL   = 8'h92;
    localparam logic [7:0] OP_ID_QUAD   = 8'h94;
    localparam logic [7:0] OP_SEC_READ  = 8'h48;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG  = 8'h42;
    // frame bit counts (rising sclk edges; ADDR_BITS and PL_BITS_MAX in payload bits)
    localparam logic [7:0] OPC_BITS     = 8'd8;
    localparam logic [7:0] LEN_ONE_BYTE = 8'd16;
    localparam logic [7:0] LEN_TWO_BYTE = 8'd24;
    localparam logic [7:0] LEN_THR_BYTE = 8'd32;
    localparam logic [7:0] D_RD_SR      = 8'd8;
    localparam logic [7:0] D_ID_SINGLE  = 8'd32;
    localparam logic [7:0] D_ID_DUAL    = 8'd24;
    localparam logic [7:0] D_ID_QUAD    = 8'd20;
    localparam logic [5:0] ADDR_BITS    = 6'd24;
    localparam logic [5:0] PL_BITS_MAX  = 6'd32;
    // status bit fields
    localparam int         SR1_BUSY     = 0;
    localparam int         SR1_WEL      = 1;
    localparam logic [7:0] SR1_WR_MASK  = 8'hfc;
    localparam logic [7:0] SR2_WR_MASK  = 8'h7b;
    localparam logic [7:0] SR2_VOL_MASK = 8'h42;
    localparam logic [7:0] SR2_LOCK     = 8'h38;
    localparam logic [7:0] SR3_WR_MASK  = 8'h61;
    localparam logic [7:0] SEC_HI_ZERO  = 8'h00;
    // timing
    localparam int         CLK_NS       = 4;
    localparam int         T_WRITE_NS   = 8000;
    localparam int         WRITE_CYCLES = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [7:0] s3;
        logic [7:0] s2;
        logic [7:0] s1;
    } fis_status_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
        logic [1:0] sel;
        logic [7:0] offset;
        logic       addr_ok;
    } fis_sec_req_t;

    localparam fis_status_t SR_RESET = 24'h000000;
endpackage

// ### logic/fis_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module fis_cmd #(
    parameter int         WRITE_CNT = fis_pkg::WRITE_CYCLES,
    parameter logic [7:0] MFR_ID    = 8'ha5,   // arbitrary value
    parameter logic [7:0] DEV_ID    = 8'h3c    // arbitrary value
) (
    // system clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // spi link
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic [3:0]           io_in,
    output logic [3:0]                io_out,
    output logic [3:0]                io_oe_n,
    // array side
    input  wire fis_pkg::fis_status_t nv_init,
    input  wire logic                 array_busy,
    input  wire logic                 array_done,
    // status and requests
    output fis_pkg::fis_status_t      status,
    output logic                      busy,
    output fis_pkg::fis_sec_req_t     sec_req
);
    import fis_pkg::*;

    localparam int WCW = $clog2(WRITE_CNT + 1);

    // ------------------------------------------------
    // link domain: frame capture on rising sclk
    // ------------------------------------------------
    logic        fresh_q;
    logic        tog_q;
    logic [7:0]  cnt_q;
    logic        long_q;
    logic [7:0]  op_q;
    logic [31:0] pl_q;
    logic [5:0]  plb_q;
    logic [23:0] addr_q;
    logic [3:0]  out_q;
    logic [3:0]  oe_n_q;
    fis_status_t hold_sr_q;
    logic        hold_dp_q;

    // marks the first edge of a frame; set by chip select itself
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // ------------------------------------------------
    // link domain: lane width and payload shift
    // ------------------------------------------------
    wire        op_ok    = long_q | (cnt_q >= OPC_BITS);
    wire [7:0]  op_shift = {op_q[6:0], io_in[0]};
    wire        is_dual  = (op_q == OP_ID_DUAL);
    wire        is_quad  = (op_q == OP_ID_QUAD);
    wire [5:0]  in_w     = is_quad ? 6'd4 : (is_dual ? 6'd2 : 6'd1);
    wire [31:0] pl_sh1   = {pl_q[30:0], io_in[0]};
    wire [31:0] pl_sh2   = {pl_q[29:0], io_in[1], io_in[0]};
    wire [31:0] pl_sh4   = {pl_q[27:0], io_in[3:0]};
    wire [31:0] pl_d     = is_quad ? pl_sh4 : (is_dual ? pl_sh2 : pl_sh1);
    wire [5:0]  plb_d    = plb_q + in_w;
    wire        addr_hit = (plb_d == ADDR_BITS) && (plb_q < ADDR_BITS);

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            tog_q  <= 1'b0;
            cnt_q  <= 8'h00;
            long_q <= 1'b0;
            op_q   <= 8'h00;
            pl_q   <= 32'h00000000;
            plb_q  <= 6'h00;
            addr_q <= 24'h000000;
        end else if (fresh_q) begin
            tog_q  <= ~tog_q;
            cnt_q  <= 8'h01;
            long_q <= 1'b0;
            op_q   <= op_shift;
            plb_q  <= 6'h00;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            long_q <= long_q | (cnt_q == 8'hff);
            if (!op_ok) begin
                op_q <= op_shift;
            end else begin
                pl_q <= pl_d;
                if (plb_q < PL_BITS_MAX) begin
                    plb_q <= plb_d;
                end
                if (addr_hit) begin
                    addr_q <= pl_d[23:0];
                end
            end
        end
    end

    // ------------------------------------------------
    // link domain: answer on falling sclk
    // ------------------------------------------------
    wire        is_rd    = (op_q == OP_RD_SR1) || (op_q == OP_RD_SR2) || (op_q == OP_RD_SR3);
    wire        is_rel   = (op_q == OP_RELEASE);
    wire        is_leg   = (op_q == OP_ID_LEGACY);
    wire        is_out   = is_rd | is_rel | is_leg | is_dual | is_quad;
    wire        h_busy   = hold_sr_q.s1[SR1_BUSY];
    // while busy only status reads answer; in power-down only release
    wire        allow    = hold_dp_q ? is_rel : (h_busy ? is_rd : 1'b1);
    wire [7:0]  d_start  = is_rd ? D_RD_SR : (is_dual ? D_ID_DUAL :
                           (is_quad ? D_ID_QUAD : D_ID_SINGLE));
    wire [7:0]  k        = cnt_q - d_start;
    wire        out_on   = op_ok & is_out & allow & (long_q | (cnt_q >= d_start));
    wire        second   = is_quad ? k[1] : (is_dual ? k[2] : k[3]);

    // ------------------------------------------------
    // link domain: answer byte and lane mapping
    // ------------------------------------------------
    wire [7:0]  id_a     = addr_q[0] ? DEV_ID : MFR_ID;
    wire [7:0]  id_b     = addr_q[0] ? MFR_ID : DEV_ID;
    wire [7:0]  rd_byte  = (op_q == OP_RD_SR2) ? hold_sr_q.s2 :
                           ((op_q == OP_RD_SR3) ? hold_sr_q.s3 : hold_sr_q.s1);
    wire [7:0]  cur      = is_rd ? rd_byte : (is_rel ? DEV_ID : (second ? id_b : id_a));
    wire        s_bit    = cur[~k[2:0]];
    wire [1:0]  d_pair   = {cur[{~k[1:0], 1'b1}], cur[{~k[1:0], 1'b0}]};
    wire [3:0]  q_nib    = k[0] ? cur[3:0] : cur[7:4];
    wire [3:0]  nx_out   = is_quad ? q_nib : (is_dual ? {2'b00, d_pair} : {2'b00, s_bit, 1'b0});
    wire [3:0]  nx_oe_n  = !out_on ? 4'hf : (is_quad ? 4'h0 : (is_dual ? 4'hc : 4'hd));

    // ------------------------------------------------
    // link domain: output registers
    // ------------------------------------------------
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_q  <= 4'h0;
            oe_n_q <= 4'hf;
        end else begin
            out_q  <= nx_out;
            oe_n_q <= nx_oe_n;
        end
    end

    assign io_out  = out_q;
    assign io_oe_n = oe_n_q;

    // ------------------------------------------------
    // system domain: frame end detection
    // ------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic cs_lvl_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic seen_q;

    // chip select level counts once the second and third stages agree
    wire cs_lvl_d  = (cs_s2_q == cs_s3_q) ? cs_s3_q : cs_lvl_q;
    wire end_ev    = cs_lvl_d & ~cs_lvl_q;
    // link registers are idle and stable once chip select is high
    wire new_frame = end_ev & (tog_s2_q != seen_q);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            cs_lvl_q <= 1'b1;
        end else begin
            cs_s1_q  <= cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            cs_lvl_q <= cs_lvl_d;
        end
    end

    // frame toggle from the link, compared at each frame end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            seen_q   <= 1'b0;
        end else begin
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            if (end_ev) begin
                seen_q <= tog_s2_q;
            end
        end
    end

    // ------------------------------------------------
    // system domain: command execution
    // ------------------------------------------------
    fis_status_t  sr_q;
    fis_status_t  pend_q;
    fis_status_t  status_q;
    fis_sec_req_t sec_q;
    logic         loaded_q;
    logic         wel_q;
    logic         wevol_q;
    logic         dp_q;
    logic [WCW-1:0] wcnt_q;

    wire busy_now  = (wcnt_q != '0) | array_busy;
    wire idle_ok   = new_frame & ~dp_q & ~busy_now & loaded_q;
    wire exact8    = ~long_q & (cnt_q == OPC_BITS);
    wire len1      = ~long_q & (cnt_q == LEN_ONE_BYTE);
    wire len2      = ~long_q & (cnt_q == LEN_TWO_BYTE);
    wire len3      = ~long_q & (cnt_q == LEN_THR_BYTE);
    wire op_w1     = (op_q == OP_WR_SR1);
    wire op_w2     = (op_q == OP_WR_SR2);
    wire op_w3     = (op_q == OP_WR_SR3);
    wire wr_ok     = (op_w1 & (len1 | len2 | len3)) | ((op_w2 | op_w3) & len1);

    // ------------------------------------------------
    // system domain: command decode
    // ------------------------------------------------
    wire do_wren   = idle_ok & exact8 & (op_q == OP_WR_EN);
    wire do_wrdi   = idle_ok & exact8 & (op_q == OP_WR_DIS);
    wire do_wevol  = idle_ok & exact8 & (op_q == OP_WR_EN_VOL);
    wire do_dp     = idle_ok & exact8 & (op_q == OP_PWR_DOWN);
    wire do_rel    = new_frame & op_ok & is_rel & ~busy_now;
    wire do_vwr    = idle_ok & wr_ok & wevol_q;
    wire do_nvwr   = idle_ok & wr_ok & ~wevol_q & wel_q;
    wire do_sec    = idle_ok & (long_q | (cnt_q >= LEN_THR_BYTE)) &
                     ((op_q == OP_SEC_READ) | (op_q == OP_SEC_ERASE) | (op_q == OP_SEC_PROG));
    wire commit    = (wcnt_q == WCW'(1));

    // ------------------------------------------------
    // system domain: status merge
    // ------------------------------------------------

    // data bytes sit at the low end of the payload shifter
    wire [7:0] b1  = len1 ? pl_q[7:0] : (len2 ? pl_q[15:8] : pl_q[23:16]);
    wire [7:0] b2  = (op_w2 | len2) ? pl_q[7:0] : pl_q[15:8];
    wire [7:0] b3  = pl_q[7:0];
    wire       w1  = op_w1;
    wire       w2  = (op_w1 & (len2 | len3)) | op_w2;
    wire       w3  = (op_w1 & len3) | op_w3;
    wire [7:0] m2  = wevol_q ? SR2_VOL_MASK : SR2_WR_MASK;

    fis_status_t nx_sr;
    assign nx_sr.s1 = w1 ? ((sr_q.s1 & ~SR1_WR_MASK) | (b1 & SR1_WR_MASK)) : sr_q.s1;
    assign nx_sr.s2 = (w2 ? ((sr_q.s2 & ~m2) | (b2 & m2)) : sr_q.s2)
                      | (sr_q.s2 & SR2_LOCK);
    assign nx_sr.s3 = w3 ? ((sr_q.s3 & ~SR3_WR_MASK) | (b3 & SR3_WR_MASK)) : sr_q.s3;

    fis_status_t status_d;
    assign status_d.s3 = sr_q.s3;
    assign status_d.s2 = sr_q.s2;
    assign status_d.s1 = {sr_q.s1[7:2], wel_q, busy_now};

    // ------------------------------------------------
    // system domain: latches and requests
    // ------------------------------------------------
    // set wins over every clear source
    wire wel_d   = do_wren ? 1'b1 :
                   ((do_wrdi | commit | array_done) ? 1'b0 : wel_q);
    wire wevol_d = new_frame ? do_wevol : wevol_q;
    wire dp_d    = do_dp ? 1'b1 : (do_rel ? 1'b0 : dp_q);

    fis_sec_req_t sec_d;
    assign sec_d.valid   = do_sec;
    assign sec_d.cmd     = op_q;
    assign sec_d.sel     = addr_q[13:12];
    assign sec_d.offset  = addr_q[7:0];
    assign sec_d.addr_ok = (addr_q[23:16] == SEC_HI_ZERO) &&
                           (addr_q[15:8] == {2'b00, addr_q[13:12], 4'h0});

    // ------------------------------------------------
    // system domain: register update
    // ------------------------------------------------
    // latches and the one-cycle power-up load
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
            wel_q    <= 1'b0;
            wevol_q  <= 1'b0;
            dp_q     <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
            wel_q    <= wel_d;
            wevol_q  <= wevol_d;
            dp_q     <= dp_d;
        end
    end

    // self-timed stored write; busy for the whole count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wcnt_q <= '0;
        end else if (do_nvwr) begin
            wcnt_q <= WCW'(WRITE_CNT);
        end else if (wcnt_q != '0) begin
            wcnt_q <= wcnt_q - WCW'(1);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sr_q   <= SR_RESET;
            pend_q <= SR_RESET;
        end else if (!loaded_q) begin
            sr_q   <= nv_init;
        end else if (do_vwr) begin
            sr_q   <= nx_sr;
        end else if (do_nvwr) begin
            pend_q <= nx_sr;
        end else if (commit) begin
            sr_q   <= pend_q;
        end
    end

    // ------------------------------------------------
    // system domain: outputs and link snapshot
    // ------------------------------------------------
    // registered status and security request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q  <= SR_RESET;
            sec_q     <= '0;
        end else begin
            status_q  <= status_d;
            sec_q     <= sec_d;
        end
    end

    // snapshot for the link; frozen while a frame is open
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hold_sr_q <= SR_RESET;
            hold_dp_q <= 1'b0;
        end else if (cs_lvl_q) begin
            hold_sr_q <= status_d;
            hold_dp_q <= dp_q;
        end
    end

    assign status  = status_q;
    assign busy    = status_q.s1[SR1_BUSY];
    assign sec_req = sec_q;
endmodule
`default_nettype wire

// ### verification/fis_cmd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fis_cmd_properties #(
    parameter int WRITE_CNT = fis_pkg::WRITE_CYCLES
) (
    // system clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // spi link
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic [3:0]           io_in,
    input  wire logic [3:0]           io_out,
    input  wire logic [3:0]           io_oe_n,
    // array side
    input  wire fis_pkg::fis_status_t nv_init,
    input  wire logic                 array_busy,
    input  wire logic                 array_done,
    // status and requests
    input  wire fis_pkg::fis_status_t status,
    input  wire logic                 busy,
    input  wire fis_pkg::fis_sec_req_t sec_req
);
    import fis_pkg::*;
    // edges since reset, length of the busy run, array activity inside it
    logic [2:0]  up_q;
    logic [11:0] bcnt_q;
    logic        arr_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            up_q   <= 3'h0;
            bcnt_q <= 12'h000;
            arr_q  <= 1'b0;
        end else begin
            up_q   <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
            bcnt_q <= busy ? bcnt_q + 12'h001 : 12'h000;
            arr_q  <= busy ? (arr_q | array_busy) : array_busy;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_OE_IDLE: assert property (cs_n |-> io_oe_n == 4'hf)
        else $error("outputs enabled while deselected");
    AST_POWERUP: assert property (up_q == 3'h2 |-> ##[0:3] (status[23:2] == nv_init[23:2] && !status.s1[SR1_WEL]))
        else $error("stored status not restored after reset");
    AST_RO_BITS: assert property (up_q == 3'h7 |-> $stable(status.s2 & ~SR2_WR_MASK) && $stable(status.s3 & ~SR3_WR_MASK))
        else $error("read-only status bit changed");
    AST_LOCK_STICKY: assert property (up_q == 3'h7 |-> ($past(status.s2) & SR2_LOCK & ~status.s2) == 8'h00)
        else $error("lock bit returned to zero");
    AST_BUSY_SPAN: assert property (busy && !arr_q |-> bcnt_q <= WRITE_CNT + 1)
        else $error("write cycle too long");
    AST_BUSY_END: assert property ($fell(busy) && !$past(arr_q) |-> $past(bcnt_q) + 2 >= WRITE_CNT)
        else $error("write cycle too short");
    AST_WEL_AT_END: assert property ($fell(busy) && !$past(arr_q) |-> ##[0:1] !status.s1[SR1_WEL])
        else $error("latch still set after write cycle");
    AST_DONE_CLEARS: assert property (array_done && cs_n |-> ##[1:3] !status.s1[SR1_WEL])
        else $error("latch not cleared on array completion");
    AST_ARRAY_BUSY: assert property ($rose(array_busy) |-> ##[1:4] busy)
        else $error("busy not raised for array cycle");
    AST_SEC_PULSE: assert property (sec_req.valid |=> !sec_req.valid)
        else $error("security request longer than one cycle");
endmodule
bind fis_cmd fis_cmd_properties #(.WRITE_CNT(WRITE_CNT)) chk_u (
    .clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .nv_init(nv_init), .array_busy(array_busy), .array_done(array_done),
    .status(status), .busy(busy), .sec_req(sec_req));
`default_nettype wire

// ### verification/fis_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fis_host_model (
    // spi pins
    output logic       sclk,
    output logic       cs_n,
    output logic [3:0] io_h,
    input  wire logic [3:0] io_in
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        io_h = 4'h0;
        // a real rise of select clears the link's output stage at start
        #1 cs_n = 1'b1;
    end
    // opcode on one lane, then ln lanes for payload and answer; sclk rests low between frames
    task automatic frame(input logic [7:0] op, input int ln, input logic [47:0] pl,
                         input int nb, input int nr, output logic [15:0] rd);
        logic [55:0] tx;
        int          k;
        tx = {op, pl};
        rd = 16'h0000;
        #1.7;
        cs_n = 1'b0;
        for (int c = 0; c < 8 + (nb + nr) / ln; c++) begin
            k = (c < 8) ? 1 : ln;
            io_h = ~io_h;
            if (c < 8 + nb / ln) begin
                for (int j = k - 1; j >= 0; j--) begin
                    io_h[j] = tx[55];
                    tx = tx << 1;
                end
            end
            #24 sclk = 1'b1;
            if (c >= 8 + nb / ln) begin
                for (int j = k - 1; j >= 0; j--) begin
                    rd = {rd[14:0], io_in[(k == 1) ? 1 : j]};
                end
            end
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        #96;
    endtask
endmodule
`default_nettype wire

// ### verification/flash_id_status_cmd_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_id_status_cmd_logic_tb_top;
    import fis_pkg::*;
    typedef struct packed {
        logic [7:0]  op;
        int          ln;
        logic [47:0] pl;
        int          nb;
        int          nr;
        logic [15:0] er;
        logic [23:0] es;
    } fis_row_t;
    localparam fis_status_t NV = 24'h20021c;
    logic         clock, resetn, array_busy, array_done, busy, sclk, cs_n;
    logic [3:0]   io_h, io_out, io_oe_n;
    wire  [3:0]   io_in;
    fis_status_t  nv_init, status;
    fis_sec_req_t sec_req, sec_seen;
    fis_row_t     rows[$];
    logic [15:0]  rd;
    logic [23:0]  adr;
    int           error_cnt, tests_run;
    assign io_in = (io_oe_n & io_h) | (~io_oe_n & io_out);
    always #2 clock = ~clock;
    always @(posedge clock) if (sec_req.valid) sec_seen <= sec_req;
    fis_cmd #(.WRITE_CNT(400)) dut_u (.clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .nv_init(nv_init), .array_busy(array_busy),
        .array_done(array_done), .status(status), .busy(busy), .sec_req(sec_req));
    fis_host_model host_u (.sclk(sclk), .cs_n(cs_n), .io_h(io_h), .io_in(io_in));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic r(input logic [7:0] o, input int l, input logic [47:0] p, input int b,
                     input int n, input logic [15:0] e, input logic [23:0] s);
        rows.push_back('{o, l, p, b, n, e, s});
    endtask
    task automatic wait_idle;
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 1000) begin
            @(negedge clock);
            t++;
        end
        check({23'h0, busy}, 24'h0);
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        nv_init = NV;
        array_busy = 1'b0;
        array_done = 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
        r(8'h05, 1, 48'h0, 0, 8, 16'h001c, 24'h20021c);
        r(8'h35, 1, 48'h0, 0, 8, 16'h0002, 24'h20021c);
        r(8'h15, 1, 48'h0, 0, 8, 16'h0020, 24'h20021c);
        r(8'h06, 1, 48'h0, 0, 0, 16'h0000, 24'h20021e);
        r(8'h04, 1, 48'h0, 0, 0, 16'h0000, 24'h20021c);
        r(8'h01, 1, 48'hff0000000000, 8, 0, 16'h0000, 24'h20021c);
        r(8'h06, 1, 48'h0, 0, 0, 16'h0000, 24'h20021e);
        r(8'h01, 1, 48'hff0000000000, 8, 0, 16'h0000, 24'h2002fc);
        r(8'h06, 1, 48'h0, 0, 0, 16'h0000, 24'h2002fe);
        r(8'h01, 1, 48'h00ffff000000, 24, 0, 16'h0000, 24'h617b00);
        r(8'h50, 1, 48'h0, 0, 0, 16'h0000, 24'h617b00);
        r(8'h31, 1, 48'h0, 8, 0, 16'h0000, 24'h613900);
        r(8'h06, 1, 48'h0, 0, 0, 16'h0000, 24'h613902);
        r(8'h31, 1, 48'h0, 8, 0, 16'h0000, 24'h613800);
        r(8'h50, 1, 48'h0, 0, 0, 16'h0000, 24'h613800);
        r(8'h05, 1, 48'h0, 0, 8, 16'h0000, 24'h613800);
        r(8'h11, 1, 48'h0, 8, 0, 16'h0000, 24'h613800);
        r(8'h06, 1, 48'h0, 0, 0, 16'h0000, 24'h613802);
        r(8'h01, 1, 48'h00f000000000, 12, 0, 16'h0000, 24'h613802);
        r(8'hab, 1, 48'h0, 24, 16, 16'h3c3c, 24'h613802);
        r(8'h90, 1, 48'h0, 24, 16, 16'ha53c, 24'h613802);
        r(8'h90, 1, 48'h000001000000, 24, 16, 16'h3ca5, 24'h613802);
        r(8'h92, 2, 48'h000001000000, 32, 16, 16'h3ca5, 24'h613802);
        r(8'h94, 4, 48'h000001000000, 48, 16, 16'h3ca5, 24'h613802);
        r(8'hff, 1, 48'h0, 8, 0, 16'h0000, 24'h613802);
        foreach (rows[i]) begin
            host_u.frame(rows[i].op, rows[i].ln, rows[i].pl, rows[i].nb, rows[i].nr, rd);
            wait_idle();
            if (rows[i].nr != 0) check({8'h00, rd}, {8'h00, rows[i].er});
            check(status, rows[i].es);
        end
        for (int i = 0; i < 5; i++) begin
            adr = (i < 4) ? {8'h00, 4'(i), 4'h0, 8'(i + 3)} : 24'h010000;
            host_u.frame(OP_SEC_READ, 1, {adr, 24'h0}, 32, 8, rd);
            check({4'h0, sec_seen}, {4'h0, 1'b1, OP_SEC_READ, adr[13:12], adr[7:0], i < 4});
        end
        host_u.frame(OP_WR_SR1, 1, 48'hff0000000000, 8, 0, rd);
        host_u.frame(OP_WR_SR2, 1, 48'hff0000000000, 8, 0, rd);
        host_u.frame(OP_RD_SR1, 1, 48'h0, 0, 8, rd);
        check({8'h00, rd}, 24'h000003);
        wait_idle();
        check(status, 24'h6138fc);
        host_u.frame(OP_WR_EN, 1, 48'h0, 0, 0, rd);
        @(posedge clock);
        array_busy <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        check({23'h0, busy}, 24'h000001);
        array_busy <= 1'b0;
        array_done <= 1'b1;
        @(posedge clock);
        array_done <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        check(status, 24'h6138fc);
        host_u.frame(OP_WR_EN_VOL, 1, 48'h0, 0, 0, rd);
        host_u.frame(OP_WR_SR1, 1, 48'h0, 8, 0, rd);
        check(status, 24'h613800);
        host_u.frame(OP_PWR_DOWN, 1, 48'h0, 0, 0, rd);
        host_u.frame(OP_WR_EN, 1, 48'h0, 0, 0, rd);
        host_u.frame(OP_RELEASE, 1, 48'h0, 24, 16, rd);
        check({8'h00, rd}, 24'h003c3c);
        check(status, 24'h613800);
        host_u.frame(OP_WR_EN, 1, 48'h0, 0, 0, rd);
        check(status, 24'h613802);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check(status, 24'h000000);
        check({20'h0, io_oe_n}, 24'h00000f);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        check(status, NV);
        tally_and_finish();
    end
endmodule
`default_nettype wire
